//--- design/sfwp_range_decode.sv
// Decoder from protect bits and complement bit to a protected address range.
// Purely combinational, so the range always tracks the current status bits.
`timescale 1ns/10ps
`default_nettype none
module sfwp_range_decode
   import sfwp_pkg::*;
(
   input  wire logic [4:0]  protect_bits,
   input  wire logic        protect_complement,
   output logic             range_valid,
   output logic [17:0]      range_lo,
   output logic [17:0]      range_hi
);

   logic [18:0] size_w;
   logic        bottom_w;
   logic [18:0] lo_w;
   logic [18:0] hi_w;

   ////////////////////////////////////////////////////////////////////////////////
   // Size and anchor first; the complement is then just the remaining bytes at the
   // opposite end, which keeps both tables in one small piece of logic.
   always_comb begin
      size_w   = '0;
      bottom_w = protect_bits[3];
      if (!protect_bits[4]) begin
         case (protect_bits[1:0])
            2'b01:   size_w = SZ_64K;
            2'b10:   size_w = SZ_128K;
            2'b11:   size_w = ARRAY_BYTES;
            default: size_w = '0;
         endcase
      end else begin
         case (protect_bits[2:0])
            3'b001:  size_w = SZ_4K;
            3'b010:  size_w = SZ_8K;
            3'b011:  size_w = SZ_16K;
            3'b100:  size_w = SZ_32K;
            3'b101:  size_w = SZ_32K;
            3'b110:  size_w = SZ_32K;
            3'b111:  size_w = ARRAY_BYTES;
            default: size_w = '0;
         endcase
      end
      if (protect_complement) begin
         size_w   = ARRAY_BYTES - size_w;
         bottom_w = !bottom_w;
      end
      lo_w = bottom_w ? 19'h00000 : ARRAY_BYTES - size_w;
      hi_w = bottom_w ? size_w - 19'h00001 : {1'b0, ARRAY_TOP};
   end

   assign range_valid = (size_w != 19'h00000);
   assign range_lo    = lo_w[17:0];
   assign range_hi    = hi_w[17:0];

endmodule // sfwp_range_decode
`default_nettype wire

//--- design/sfwp_write_protect.sv
// Write-protection, write-latch and suspend-status logic of a serial NOR flash,
// with its command, address and status registers behind an AHB-Lite slave.
// Assumes the SPI front end has already framed each command into the command
// register, with flags telling whether it was complete and byte aligned.
//
// Contract
// - Readable writable complement bit, default zero.
// - Suspended erase sets erase suspended flag.
// - Suspended program sets program suspended flag.
// - Status writes never change suspend flags.
// - Resume or power cycle clears suspend flags.
// - Power-up resets into standby.
// - Only complete well-formed commands change memory.
// - Reject commands not ending on byte boundary; a release in deep power-down skips this check.
// - Modifying commands need write latch set first.
// - Protected region readable, never programmed or erased.
// - Write-protect low freezes protect and lock bits.
// - Deep power-down ignores all but release.
// - Decode protect bits without complement.
// - Complement protects exactly the unprotected remainder.
// - Ignore program or erase touching protected area.
// - Clear latch refuses status, program, erase.
// - Chip erase only when nothing protected.
// - Lock bits 0,1 with pin low lock status.
`timescale 1ns/10ps
`default_nettype none
module sfwp_write_protect
   import sfwp_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        wp_n,
   input  wire logic        array_done,
   output logic             array_op_valid,
   output logic [7:0]       array_op_code,
   output logic [17:0]      array_op_lo,
   output logic [17:0]      array_op_hi,
   output logic             deep_power_down
);

   typedef struct packed {
      sfwp_bus_type bus;
      logic [7:0]   waddr;
      logic [15:0]  sr;
      logic [17:0]  cmd_addr;
      logic [15:0]  sr_data;
      logic [7:0]   last_op;
      logic [5:0]   result;
      logic         deep;
      logic         erase_op;
      logic [31:0]  rdata;
      logic         op_valid;
      logic [7:0]   op_code;
      logic [17:0]  op_lo;
      logic [17:0]  op_hi;
   } sfwp_state_type;

   sfwp_state_type s_q;
   sfwp_state_type s_d;

   logic        prot_valid;
   logic [17:0] prot_lo;
   logic [17:0] prot_hi;

   ////////////////////////////////////////////////////////////////////////////////
   // Bytes touched by a program or erase opcode; zero for anything else.
   function automatic logic [18:0] region_size(input logic [7:0] opc);
      case (opc)
         OP_PP, OP_PE:     region_size = SZ_PAGE;
         OP_SE:            region_size = SZ_4K;
         OP_BE32:          region_size = SZ_32K;
         OP_BE:            region_size = SZ_64K;
         OP_CE_A, OP_CE_B: region_size = ARRAY_BYTES;
         default:          region_size = '0;
      endcase
   endfunction

   // Register read mux; unmapped offsets read as zero.
   function automatic logic [31:0] reg_read(input sfwp_state_type s, input logic [7:0] off,
                                            input logic pv, input logic [17:0] lo, input logic [17:0] hi);
      reg_read = '0;
      case (off)
         REG_CMD:     reg_read[7:0] = s.last_op;
         REG_ADDR:    reg_read[17:0] = s.cmd_addr;
         REG_SR_DATA: reg_read[15:0] = s.sr_data;
         REG_STATUS:  reg_read[15:0] = s.sr;
         REG_RESULT:  reg_read = {23'h000000, s.deep, 2'b00, s.result};
         REG_PROT_LO: reg_read = {pv, 13'h0000, lo};
         REG_PROT_HI: reg_read[17:0] = hi;
         default:     reg_read = '0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Protected range decoder, driven straight from the live status bits.
   sfwp_range_decode u_decode (
      .protect_bits       (s_q.sr[ST_PB4:ST_PB0]),
      .protect_complement (s_q.sr[ST_CPL]),
      .range_valid        (prot_valid),
      .range_lo           (prot_lo),
      .range_hi           (prot_hi)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic: bus phases, then command execution on a command write.
   always_comb begin
      logic [7:0]  opc;
      logic        len_ok;
      logic        locked;
      logic [18:0] rsize;
      logic [18:0] rlo;
      logic [18:0] rhi;
      logic        hit;
      logic [15:0] nsr;
      opc    = hwdata[7:0];
      len_ok = hwdata[CMD_ALIGN_BIT] & hwdata[CMD_DONE_BIT];
      locked = (s_q.sr[ST_SLK1:ST_SLK0] == 2'b01 && !wp_n) || s_q.sr[ST_SLK1];
      rsize  = region_size(opc);
      rlo    = {1'b0, s_q.cmd_addr} & ~(rsize - 19'h00001);
      rhi    = rlo + rsize - 19'h00001;
      hit    = prot_valid && rlo <= {1'b0, prot_hi} && rhi >= {1'b0, prot_lo};
      nsr    = (s_q.sr & ~SR_WR_MASK) | (s_q.sr_data & SR_WR_MASK);
      s_d    = s_q;
      s_d.op_valid = 1'b0;

      // The array engine reports completion; a suspended operation is not running.
      if (array_done && s_q.sr[ST_WIP]) begin
         s_d.sr[ST_WIP] = 1'b0;
      end

      // Address phase is taken only while this slave is ready.
      case (s_q.bus)
         BUS_RDWAIT: begin
            s_d.rdata = reg_read(s_q, s_q.waddr, prot_valid, prot_lo, prot_hi);
            s_d.bus   = BUS_RDDONE;
         end
         default: begin
            if (hsel && htrans[1] && hready) begin
               s_d.waddr = (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hff;
               s_d.bus   = hwrite ? BUS_WRITE : BUS_RDWAIT;
            end else begin
               s_d.bus = BUS_IDLE;
            end
         end
      endcase

      // Write data phase.
      if (s_q.bus == BUS_WRITE) begin
         case (s_q.waddr)
            REG_ADDR:    s_d.cmd_addr = hwdata[17:0];
            REG_SR_DATA: s_d.sr_data = hwdata[15:0];
            REG_CMD: begin
               s_d.last_op = opc;
               s_d.result  = '0;
               if (s_q.deep) begin
                  // Only the release command is heard in deep power-down.
                  if (opc == OP_RDP) begin
                     s_d.deep = 1'b0;
                     s_d.result[RES_ACCEPT] = 1'b1;
                  end else begin
                     s_d.result[RES_IGNORE] = 1'b1;
                  end
               end else if (!len_ok) begin
                  s_d.result[RES_LEN] = 1'b1;
               end else if (s_d.sr[ST_WIP] && opc != OP_SUS_A && opc != OP_SUS_B) begin
                  s_d.result[RES_IGNORE] = 1'b1;
               end else begin
                  case (opc)
                     OP_WLON: begin
                        s_d.sr[ST_WLF] = 1'b1;
                        s_d.result[RES_ACCEPT] = 1'b1;
                     end
                     OP_WRDI: begin
                        s_d.sr[ST_WLF] = 1'b0;
                        s_d.result[RES_ACCEPT] = 1'b1;
                     end
                     OP_WRSR: begin
                        if (!s_q.sr[ST_WLF]) begin
                           s_d.result[RES_NOLATCH] = 1'b1;
                        end else if (locked) begin
                           s_d.result[RES_LOCK] = 1'b1;
                        end else begin
                           if (!wp_n) begin
                              nsr = (nsr & ~SR_HW_MASK) | (s_q.sr & SR_HW_MASK);
                           end
                           // SR_OTP_MASK bits 11 to 13 are one-time: they can be set, never cleared.
                           nsr = nsr | (s_q.sr & SR_OTP_MASK);
                           s_d.sr[ST_CPL:ST_PB0] = nsr[ST_CPL:ST_PB0];
                           s_d.sr[ST_WLF] = 1'b0;
                           s_d.result[RES_ACCEPT] = 1'b1;
                        end
                     end
                     OP_PP, OP_PE, OP_SE, OP_BE32, OP_BE, OP_CE_A, OP_CE_B: begin
                        if (!s_q.sr[ST_WLF]) begin
                           s_d.result[RES_NOLATCH] = 1'b1;
                        end else if (hit) begin
                           s_d.result[RES_PROT] = 1'b1;
                        end else if (s_q.sr[ST_ESUS] || s_q.sr[ST_PSUS]) begin
                           s_d.result[RES_IGNORE] = 1'b1;
                        end else begin
                           // Only now, with every check passed, is the array touched.
                           s_d.sr[ST_WIP]  = 1'b1;
                           s_d.sr[ST_WLF]  = 1'b0;
                           s_d.erase_op    = (opc != OP_PP);
                           s_d.op_valid    = 1'b1;
                           s_d.op_code     = opc;
                           s_d.op_lo       = rlo[17:0];
                           s_d.op_hi       = rhi[17:0];
                           s_d.result[RES_ACCEPT] = 1'b1;
                        end
                     end
                     OP_SUS_A, OP_SUS_B: begin
                        if (s_d.sr[ST_WIP]) begin
                           s_d.sr[ST_WIP] = 1'b0;
                           if (s_q.erase_op) begin
                              s_d.sr[ST_ESUS] = 1'b1;
                           end else begin
                              s_d.sr[ST_PSUS] = 1'b1;
                           end
                           s_d.op_valid = 1'b1;
                           s_d.op_code  = opc;
                           s_d.result[RES_ACCEPT] = 1'b1;
                        end else begin
                           s_d.result[RES_IGNORE] = 1'b1;
                        end
                     end
                     OP_RES_A, OP_RES_B: begin
                        // Resume restarts the held operation if one was suspended.
                        if (s_q.sr[ST_ESUS] || s_q.sr[ST_PSUS]) begin
                           s_d.sr[ST_WIP] = 1'b1;
                           s_d.op_valid   = 1'b1;
                           s_d.op_code    = opc;
                        end
                        s_d.sr[ST_ESUS] = 1'b0;
                        s_d.sr[ST_PSUS] = 1'b0;
                        s_d.result[RES_ACCEPT] = 1'b1;
                     end
                     OP_DP: begin
                        s_d.deep = 1'b1;
                        s_d.result[RES_ACCEPT] = 1'b1;
                     end
                     default: s_d.result[RES_IGNORE] = 1'b1;
                  endcase
               end
            end
            default: s_d.bus = s_d.bus;
         endcase
      end

      // Chip erase is refused whenever any region is protected.
      if (s_q.bus == BUS_WRITE && s_q.waddr == REG_CMD && !s_q.deep && len_ok && s_q.sr[ST_WLF]
          && !s_q.sr[ST_WIP] && (opc == OP_CE_A || opc == OP_CE_B) && prot_valid) begin
         s_d.sr[ST_WIP] = s_q.sr[ST_WIP];
         s_d.sr[ST_WLF] = s_q.sr[ST_WLF];
         s_d.op_valid   = 1'b0;
         s_d.result     = '0;
         s_d.result[RES_PROT] = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register. Reset is the power cycle: standby, flags and latch cleared.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q     <= '0;
         s_q.bus <= BUS_IDLE;
         s_q.sr  <= STATUS_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs. Reads take one wait state so they always see the latest write.
   assign hrdata          = s_q.rdata;
   assign hreadyout       = (s_q.bus != BUS_RDWAIT);
   assign hresp           = 1'b0;
   assign array_op_valid  = s_q.op_valid;
   assign array_op_code   = s_q.op_code;
   assign array_op_lo     = s_q.op_lo;
   assign array_op_hi     = s_q.op_hi;
   assign deep_power_down = s_q.deep;

endmodule // sfwp_write_protect
`default_nettype wire

//--- inc/sfwp_pkg.sv
// Shared constants and types for the flash write-protection block.
// Assumes an 18-bit byte address array and a 32-bit AHB-Lite register bus.
package sfwp_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Array geometry and region sizes, in bytes.
   localparam logic [18:0] ARRAY_BYTES = 19'h40000;
   localparam logic [17:0] ARRAY_TOP   = 18'h3ffff;
   localparam logic [18:0] SZ_PAGE     = 19'h00100;
   localparam logic [18:0] SZ_4K       = 19'h01000;
   localparam logic [18:0] SZ_8K       = 19'h02000;
   localparam logic [18:0] SZ_16K      = 19'h04000;
   localparam logic [18:0] SZ_32K      = 19'h08000;
   localparam logic [18:0] SZ_64K      = 19'h10000;
   localparam logic [18:0] SZ_128K     = 19'h20000;

   ////////////////////////////////////////////////////////////////////////////////
   // Register byte offsets.
   localparam logic [7:0] REG_CMD     = 8'h00;
   localparam logic [7:0] REG_ADDR    = 8'h04;
   localparam logic [7:0] REG_SR_DATA = 8'h08;
   localparam logic [7:0] REG_STATUS  = 8'h0c;
   localparam logic [7:0] REG_RESULT  = 8'h10;
   localparam logic [7:0] REG_PROT_LO = 8'h14;
   localparam logic [7:0] REG_PROT_HI = 8'h18;

   // Command, protect-low and result register fields.
   localparam int unsigned CMD_ALIGN_BIT = 8;
   localparam int unsigned CMD_DONE_BIT  = 9;
   localparam int unsigned PROT_VALID_BIT = 31;
   localparam int unsigned RES_DEEP_BIT   = 8;

   ////////////////////////////////////////////////////////////////////////////////
   // Status register bit positions and masks.
   localparam int unsigned ST_WIP  = 0;
   localparam int unsigned ST_WLF  = 1;
   localparam int unsigned ST_PB0  = 2;
   localparam int unsigned ST_PB4  = 6;
   localparam int unsigned ST_SLK0 = 7;
   localparam int unsigned ST_SLK1 = 8;
   localparam int unsigned ST_PSUS = 10;
   localparam int unsigned ST_CPL  = 14;
   localparam int unsigned ST_ESUS = 15;
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [15:0] SR_WR_MASK   = 16'h79fc;
   localparam logic [15:0] SR_HW_MASK   = 16'h01fc;
   localparam logic [15:0] SR_OTP_MASK  = 16'h3800;

   ////////////////////////////////////////////////////////////////////////////////
   // Command opcodes.
   localparam logic [7:0] OP_WLON  = 8'h06;
   localparam logic [7:0] OP_WRDI  = 8'h04;
   localparam logic [7:0] OP_WRSR  = 8'h01;
   localparam logic [7:0] OP_PP    = 8'h02;
   localparam logic [7:0] OP_PE    = 8'h81;
   localparam logic [7:0] OP_SE    = 8'h20;
   localparam logic [7:0] OP_BE32  = 8'h52;
   localparam logic [7:0] OP_BE    = 8'hd8;
   localparam logic [7:0] OP_CE_A  = 8'h60;
   localparam logic [7:0] OP_CE_B  = 8'hc7;
   localparam logic [7:0] OP_SUS_A = 8'h75;
   localparam logic [7:0] OP_SUS_B = 8'hb0;
   localparam logic [7:0] OP_RES_A = 8'h7a;
   localparam logic [7:0] OP_RES_B = 8'h30;
   localparam logic [7:0] OP_DP    = 8'hb9;
   localparam logic [7:0] OP_RDP   = 8'hab;

   // Result register one-hot outcome positions.
   localparam int unsigned RES_ACCEPT  = 0;
   localparam int unsigned RES_NOLATCH = 1;
   localparam int unsigned RES_PROT    = 2;
   localparam int unsigned RES_LEN     = 3;
   localparam int unsigned RES_LOCK    = 4;
   localparam int unsigned RES_IGNORE  = 5;

   // Bus slave phase.
   typedef enum logic [3:0] {
      BUS_IDLE   = 4'b0001,
      BUS_WRITE  = 4'b0010,
      BUS_RDWAIT = 4'b0100,
      BUS_RDDONE = 4'b1000
   } sfwp_bus_type;

endpackage

//--- tb/sfwp_array_model.sv
// Behavioural array engine that answers launched operations with a done pulse.
// Assumes operation pulses from the block; stall stretches an operation at will.
`timescale 1ns/10ps
`default_nettype none
module sfwp_array_model
   import sfwp_pkg::*;
#(
   parameter int DELAY = 4
)
(
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       stall,
   input  wire logic       op_valid,
   input  wire logic [7:0] op_code,
   output logic            done
);
   logic       busy_q;
   logic [7:0] cnt_q;
   // A suspend halts the work, so no done pulse may follow it.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_q <= 1'b0;
         cnt_q  <= 8'h00;
         done   <= 1'b0;
      end else begin
         done <= 1'b0;
         if (op_valid) begin
            busy_q <= !(op_code == OP_SUS_A || op_code == OP_SUS_B);
            cnt_q  <= DELAY[7:0];
         end else if (busy_q && !stall) begin
            if (cnt_q == 8'h00) begin
               busy_q <= 1'b0;
               done   <= 1'b1;
            end else begin
               cnt_q <= cnt_q - 8'h01;
            end
         end
      end
   end
endmodule // sfwp_array_model
`default_nettype wire

//--- tb/sfwp_write_protect_assertions.sv
// Checker for the write-protection block, bound to its top module ports.
// Assumes a single AHB-Lite slave whose hready input follows hreadyout.
`timescale 1ns/10ps
`default_nettype none
module sfwp_write_protect_assertions
   import sfwp_pkg::*;
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hwdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        array_op_valid,
   input wire logic [7:0]  array_op_code,
   input wire logic [17:0] array_op_lo,
   input wire logic [17:0] array_op_hi,
   input wire logic        deep_power_down
);
   logic cmd_dp_q;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence rd_take;
      hsel && htrans[1] && !hwrite && hready && hreadyout;
   endsequence
   sequence wr_take;
      hsel && htrans[1] && hwrite && hready && hreadyout;
   endsequence
   // Marks the data phase of a command write, the only cause of an operation.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_dp_q <= 1'b0;
      end else begin
         cmd_dp_q <= hsel && htrans[1] && hwrite && hready && hreadyout && haddr == 32'h0;
      end
   end
   AST_RD_WAIT: assert property (rd_take |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
   AST_WR_ZERO: assert property (wr_take |=> hreadyout) else $error("write data phase stalled");
   AST_OKAY: assert property (hresp == 1'b0) else $error("response not okay");
   AST_OP_CAUSE: assert property (array_op_valid |-> $past(cmd_dp_q)) else $error("operation without command");
   AST_BAD_LEN: assert property (cmd_dp_q && hwdata[9:8] != 2'b11 |=> !array_op_valid)
      else $error("misframed command launched");
   AST_SE_SPAN: assert property (array_op_valid && array_op_code == OP_SE |->
      array_op_hi - array_op_lo == 18'hfff && array_op_lo[11:0] == 12'h0) else $error("sector span wrong");
   AST_PP_SPAN: assert property (array_op_valid && array_op_code == OP_PP |->
      array_op_hi - array_op_lo == 18'hff && array_op_lo[7:0] == 8'h0) else $error("page span wrong");
   AST_DPD_IN: assert property ($rose(deep_power_down) |-> $past(cmd_dp_q) && $past(hwdata[7:0]) == OP_DP)
      else $error("deep power-down entered without command");
   AST_DPD_OUT: assert property ($fell(deep_power_down) |-> $past(cmd_dp_q) && $past(hwdata[7:0]) == OP_RDP)
      else $error("deep power-down left without release");
   AST_DPD_QUIET: assert property (deep_power_down && $past(deep_power_down) |-> !array_op_valid)
      else $error("operation in deep power-down");
endmodule // sfwp_write_protect_assertions
`default_nettype wire

//--- tb/tb_sfwp_write_protect.sv
// Self-checking bench for the write-protection block over AHB-Lite.
// Assumes one slave with hready looped back and the array engine model.
`timescale 1ns/10ps
`default_nettype none
module tb_sfwp_write_protect;
   import sfwp_pkg::*;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, wp_n = 1, stall = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd_v;
   logic [1:0]  htrans = 0;
   logic        hreadyout, hresp, op_valid, dpd, done;
   logic [7:0]  op_code;
   logic [17:0] op_lo, op_hi;
   int          fails = 0, comparisons = 0;
   logic [15:0] t_sr [9] = '{16'h0004, 16'h4004, 16'h0064, 16'h4064, 16'h0058, 16'h4078, 16'h400c, 16'h4000, 16'h0028};
   logic [17:0] t_lo [9] = '{18'h30000, 18'h0, 18'h0, 18'h1000, 18'h38000, 18'h8000, 18'h0, 18'h0, 18'h0};
   logic [17:0] t_hi [9] = '{18'h3ffff, 18'h2ffff, 18'hfff, 18'h3ffff, 18'h3ffff, 18'h3ffff, 18'h0, 18'h3ffff, 18'h1ffff};
   // A 4 ns clock.
   always #2 hclk = ~hclk;
   sfwp_write_protect uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .wp_n(wp_n), .array_done(done), .array_op_valid(op_valid),
      .array_op_code(op_code), .array_op_lo(op_lo), .array_op_hi(op_hi), .deep_power_down(dpd));
   sfwp_array_model model (.hclk(hclk), .hresetn(hresetn), .stall(stall), .op_valid(op_valid),
      .op_code(op_code), .done(done));
   ////////////////////////////////////////
   // Ready is looked at on the falling edge, where it is settled for the next rising edge.
   task automatic rdy;
      @(negedge hclk);
      while (hreadyout !== 1'b1) @(negedge hclk);
      rd_v = hrdata;
      @(posedge hclk);
   endtask
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      rdy();
      htrans <= 2'b00;
      hwdata <= d;
      rdy();
   endtask
   task automatic cmd(input logic [7:0] op);
      xfer(REG_CMD, 1'b1, {22'h0, 2'b11, op});
   endtask
   task automatic op_at(input logic [7:0] op, input logic [31:0] a);
      cmd(OP_WLON);
      xfer(REG_ADDR, 1'b1, a);
      cmd(op);
   endtask
   task automatic wrsr(input logic [31:0] v);
      xfer(REG_SR_DATA, 1'b1, v);
      op_at(OP_WRSR, 32'h0);
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      xfer(a, 1'b0, 32'h0);
      chk(rd_v, exp, what);
   endtask
   // Polls until the busy bit drops; the watchdog covers a hang.
   task automatic idle;
      do xfer(REG_STATUS, 1'b0, 32'h0);
      while (rd_v[0] !== 1'b0);
   endtask
   task automatic results;
      if (fails == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////
   // Watchdog, far beyond the few hundred cycles the tests need.
   initial begin
      #100000;
      fails++;
      results();
   end
   // Main sequence.
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rchk(REG_STATUS, 32'h0, "status reset");
      rchk(8'h20, 32'h0, "unmapped");
      xfer(REG_SR_DATA, 1'b1, 32'h4);
      cmd(OP_WRSR);
      rchk(REG_RESULT, 32'h2, "latch clear");
      for (int k = 0; k < 9; k++) begin
         wrsr({16'h0, t_sr[k]});
         rchk(REG_STATUS, {16'h0, t_sr[k]}, "status");
         xfer(REG_PROT_LO, 1'b0, 32'h0);
         chk({31'h0, rd_v[31]}, {31'h0, t_hi[k] != 18'h0}, "range valid");
         if (t_hi[k] != 18'h0) begin
            chk(rd_v[17:0], t_lo[k], "range low");
            rchk(REG_PROT_HI, {14'h0, t_hi[k]}, "range high");
         end
      end
      op_at(OP_SE, 32'h1f000);
      rchk(REG_RESULT, 32'h4, "protected sector");
      op_at(OP_BE, 32'h2abcd);
      rchk(REG_RESULT, 32'h1, "free block");
      chk({14'h0, op_lo}, 32'h20000, "block low");
      chk({14'h0, op_hi}, 32'h2ffff, "block high");
      idle();
      op_at(OP_CE_A, 32'h0);
      rchk(REG_RESULT, 32'h4, "chip erase protected");
      wrsr(32'h0);
      op_at(OP_CE_B, 32'h0);
      rchk(REG_RESULT, 32'h1, "chip erase");
      idle();
      cmd(OP_WLON);
      xfer(REG_CMD, 1'b1, {22'h0, 2'b01, OP_SE});
      rchk(REG_RESULT, 32'h8, "partial command");
      xfer(REG_CMD, 1'b1, {22'h0, 2'b10, OP_PP});
      rchk(REG_STATUS, 32'h2, "latch kept");
      stall <= 1'b1;
      op_at(OP_SE, 32'h0);
      cmd(OP_SUS_A);
      rchk(REG_STATUS, 32'h8000, "erase suspend");
      wrsr(32'h8400);
      rchk(REG_STATUS, 32'h8000, "flags read only");
      cmd(OP_RES_B);
      rchk(REG_STATUS, 32'h1, "erase resume");
      stall <= 1'b0;
      idle();
      stall <= 1'b1;
      op_at(OP_PP, 32'h100);
      cmd(OP_SUS_B);
      rchk(REG_STATUS, 32'h0400, "program suspend");
      cmd(OP_RES_A);
      rchk(REG_STATUS, 32'h1, "program resume");
      stall <= 1'b0;
      idle();
      stall <= 1'b1;
      op_at(OP_SE, 32'h0);
      cmd(OP_SUS_A);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      stall   <= 1'b0;
      @(posedge hclk);
      rchk(REG_STATUS, 32'h0, "power cycle");
      wp_n <= 1'b0;
      wrsr(32'h4);
      rchk(REG_STATUS, 32'h0, "pin freezes protect");
      wp_n <= 1'b1;
      wrsr(32'h80);
      wp_n <= 1'b0;
      wrsr(32'h4);
      rchk(REG_RESULT, 32'h10, "status locked");
      wp_n <= 1'b1;
      wrsr(32'h0);
      cmd(OP_DP);
      cmd(OP_WLON);
      chk({31'h0, dpd}, 32'h1, "deep entry");
      rchk(REG_RESULT, 32'h120, "deep ignores");
      cmd(OP_RDP);
      rchk(REG_STATUS, 32'h0, "no latch after deep");
      chk({31'h0, dpd}, 32'h0, "deep exit");
      results();
   end
endmodule // tb_sfwp_write_protect
bind sfwp_write_protect sfwp_write_protect_assertions u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout),
   .hresp(hresp), .array_op_valid(array_op_valid), .array_op_code(array_op_code), .array_op_lo(array_op_lo),
   .array_op_hi(array_op_hi), .deep_power_down(deep_power_down));
`default_nettype wire
